/* bench/ecc_enc_model.sv */
// Purpose: pulse encoder model driving the counter pins
// Assumes: one step request moves the encoder by one edge
// Notes: the bench spaces the steps, so slow and fast encoders both occur
`timescale 1ns/1ps
module ecc_enc_model (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // requests from the bench
    input wire logic step,
    input wire logic fwd,
    input wire logic incr,
    input wire logic b_lvl,
    input wire logic z_lvl,
    // encoder pins
    output logic phase_a,
    output logic phase_b,
    output logic index_out
);
    logic [1:0] quad_q;
    logic pulse_q;
    ////////////////////////////////////////
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            quad_q <= 2'h0;
        end else if (step && !incr) begin
            quad_q <= fwd ? quad_q + 2'h1 : quad_q - 2'h1;
        end
    end
    // single-phase mode gives one count pulse per step
    always_ff @(posedge clock) begin
        pulse_q <= rst_n && step && incr;
    end
    ////////////////////////////////////////
    // ab walks 00,10,11,01 forward; in single-phase mode b is left to the bench
    assign phase_a = incr ? pulse_q : quad_q[0] ^ quad_q[1];
    assign phase_b = incr ? b_lvl : quad_q[1];
    assign index_out = z_lvl;
endmodule

/* bench/ecc_top_tb.sv */
// Purpose: self-checking bench for the encoder counter block
// Assumes: short scan period, apb master in bench tasks
// Notes: expected counts are tracked by the bench and compared with the count words read back
`timescale 1ns/1ps
module ecc_top_tb;
    import ecc_pkg::*;
    localparam int SCAN = 8;
    localparam logic [31:0] ALL_ONES = 32'hffffffff;
    logic clock;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, pa, pb, pz, phase_b_plain, index_plain;
    logic [15:0] match_event;
    logic [7:0] range_flags;
    logic step = 1'b0, fwd = 1'b0, incr = 1'b0, b_lvl = 1'b0, z_lvl = 1'b0;
    int err_count = 0, checks = 0, cnt = 0;
    int ev[16] = '{default: 0};
    ////////////////////////////////////////
    ecc_top #(.SCAN_CYCLES(SCAN)) dut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .phase_a_input(pa), .phase_b_input(pb), .index_reset_input(pz), .phase_b_plain(phase_b_plain),
        .index_plain(index_plain), .match_event(match_event), .range_flags(range_flags));
    ecc_enc_model enc (.clock(clock), .rst_n(rst_n), .step(step), .fwd(fwd), .incr(incr), .b_lvl(b_lvl),
        .z_lvl(z_lvl), .phase_a(pa), .phase_b(pb), .index_out(pz));
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    always @(posedge clock) begin
        for (int i = 0; i < 16; i++) begin
            if (match_event[i] === 1'b1) ev[i]++;
        end
    end
    ////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // holds the request until pready is seen at an edge, then idles one cycle
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            err_count++;
            $display("mismatch at %0t: apb answer missing", $time);
            tally_and_finish();
        end
        @(posedge clock);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m, input string w);
        apb(1'b0, a, 32'h0);
        chk(rd & m, exp, w);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic steps(input int n, input logic f, input int gap);
        repeat (n) begin
            step <= 1'b1;
            fwd <= f;
            @(posedge clock);
            step <= 1'b0;
            repeat (gap) @(posedge clock);
            cnt = f ? cnt + 1 : cnt - 1;
        end
    endtask
    // digit words: magnitude digits, leading f when negative
    function automatic logic [31:0] bcd(int v);
        int m;
        logic [31:0] r;
        m = v < 0 ? -v : v;
        r = 32'h0;
        for (int i = 0; i < 7; i++) begin
            r[4*i +: 4] = 4'(m % 10);
            m = m / 10;
        end
        if (v < 0) r[31:28] = 4'hf;
        return r;
    endfunction
    function automatic logic [7:0] rng(int c);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) r[i] = (c >= 2 * i) && (c <= 2 * i + 3);
        return r;
    endfunction
    // two scan periods pass so the words have surely refreshed
    task automatic pv_chk();
        logic [31:0] e;
        e = bcd(cnt);
        idle(2 * SCAN + 6);
        rchk(ECC_OFF_CNT_LO, {16'h0, e[15:0]}, ALL_ONES, "count low");
        rchk(ECC_OFF_CNT_HI, {16'h0, e[31:16]}, ALL_ONES, "count high");
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        rchk(ECC_OFF_CNT_LO, 32'h0, ALL_ONES, "count at reset");
        rchk(ECC_OFF_RANGE, 32'h0, ALL_ONES, "flags at reset");
        rchk(ECC_OFF_STATUS, 32'h0, ALL_ONES, "status at reset");
        apb(1'b1, 8'h30, 32'h5);
        chk({31'h0, er}, 32'h1, "unmapped error");
        apb(1'b1, ECC_OFF_CNT_LO, 32'h1234);
        rchk(ECC_OFF_CNT_LO, 32'h1234, ALL_ONES, "storage word");
        $display("reset and storage test done");
        apb(1'b1, ECC_OFF_SETUP, 32'h1);
        apb(1'b1, ECC_OFF_RUN, 32'h1);
        pv_chk();
        apb(1'b1, ECC_OFF_CMPCTL, {30'h0, ECC_CMP_START});
        rchk(ECC_OFF_STATUS, 32'h0, 32'h2, "compare without table");
        steps(12, 1'b1, 3);
        pv_chk();
        steps(14, 1'b0, 5);
        pv_chk();
        apb(1'b1, ECC_OFF_CLEAR, 32'h1);
        pv_chk();
        z_lvl <= 1'b1;
        idle(4);
        chk({31'h0, index_plain}, 32'h0, "index pin held by counter");
        z_lvl <= 1'b0;
        cnt = 0;
        pv_chk();
        apb(1'b1, ECC_OFF_CLEAR, 32'h0);
        $display("quadrature test done");
        apb(1'b1, ECC_OFF_TABLE, 32'h3);
        apb(1'b1, ECC_OFF_TABLE + 8'h04, 32'h5);
        apb(1'b1, ECC_OFF_NTGT, 32'h2);
        apb(1'b1, ECC_OFF_LOAD, {30'h0, ECC_LD_TGT});
        idle(20);
        rchk(ECC_OFF_STATUS, 32'h1, 32'h3, "loaded not comparing");
        steps(4, 1'b1, 3);
        chk(ev[0], 32'h0, "event before start");
        apb(1'b1, ECC_OFF_CMPCTL, {30'h0, ECC_CMP_START});
        steps(4, 1'b0, 3);
        steps(6, 1'b1, 4);
        steps(3, 1'b0, 3);
        idle(4);
        chk(ev[0], 32'h2, "first target wraps");
        chk(ev[1], 32'h1, "second target");
        apb(1'b1, ECC_OFF_CMPCTL, {30'h0, ECC_CMP_STOP});
        steps(3, 1'b1, 3);
        chk(ev[1], 32'h1, "stopped compare");
        apb(1'b1, ECC_OFF_CMPCTL, {30'h0, ECC_CMP_START});
        steps(1, 1'b0, 3);
        idle(4);
        chk(ev[1], 32'h2, "resumed compare");
        apb(1'b1, ECC_OFF_LOAD, {30'h0, ECC_LD_TGT_GO});
        rchk(ECC_OFF_STATUS, 32'h8, 32'ha, "copy before compare");
        idle(20);
        rchk(ECC_OFF_STATUS, 32'h3, 32'hf, "compare after copy");
        $display("target test done");
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, ECC_OFF_TABLE + 8'(4 * i), 32'(2 * i));
            apb(1'b1, ECC_OFF_TABLE + 8'(4 * i + 32), 32'(2 * i + 3));
        end
        apb(1'b1, ECC_OFF_LOAD, {30'h0, ECC_LD_RNG});
        idle(20);
        rchk(ECC_OFF_STATUS, 32'h1, 32'h3, "range loaded idle");
        chk({24'h0, range_flags}, 32'h0, "flags while idle");
        apb(1'b1, ECC_OFF_LOAD, {30'h0, ECC_LD_RNG_GO});
        idle(20);
        rchk(ECC_OFF_STATUS, 32'h7, 32'h7, "range compare on");
        steps(5, 1'b0, 3);
        repeat (8) begin
            idle(2 * SCAN);
            chk({24'h0, range_flags}, {24'h0, rng(cnt)}, "range flag pins");
            rchk(ECC_OFF_RANGE, {24'h0, rng(cnt)}, ALL_ONES, "range flag word");
            steps(1, 1'b1, 3);
        end
        $display("range test done");
        // the model's phase b is high here, so a mode change taking hold would show
        apb(1'b1, ECC_OFF_SETUP, 32'h7);
        idle(4);
        chk({31'h0, phase_b_plain}, 32'h0, "setup changed mid run");
        chk(ev[3], 32'h1, "range 3 entry event");
        chk(ev[4], 32'h1, "range 4 entry event");
        incr <= 1'b1;
        apb(1'b1, ECC_OFF_RUN, 32'h0);
        apb(1'b1, ECC_OFF_RUN, 32'h1);
        cnt = 0;
        pv_chk();
        b_lvl <= 1'b1;
        z_lvl <= 1'b1;
        idle(4);
        chk({30'h0, phase_b_plain, index_plain}, 32'h3, "freed pins high");
        b_lvl <= 1'b0;
        z_lvl <= 1'b0;
        idle(4);
        chk({30'h0, phase_b_plain, index_plain}, 32'h0, "freed pins low");
        steps(5, 1'b1, 4);
        apb(1'b1, ECC_OFF_CNT_LO, 32'h0);
        pv_chk();
        apb(1'b1, ECC_OFF_CLEAR, 32'h1);
        cnt = 0;
        pv_chk();
        apb(1'b1, ECC_OFF_CLEAR, 32'h0);
        $display("single-phase test done");
        tally_and_finish();
    end
endmodule

/* core/ecc_pkg.sv */
// Purpose: constants and types for the encoder counter with compare control
// Assumes: APB register access, 32-bit data, one clock
// Notes: table and command registers sit above the counter words
package ecc_pkg;
    localparam int ECC_CW = 18;
    localparam int ECC_NTAB = 16;
    localparam int ECC_NRANGE = 8;
    localparam int ECC_SCAN_CYCLES = 1000;
    // register byte offsets
    localparam logic [7:0] ECC_OFF_CNT_LO = 8'h00;
    localparam logic [7:0] ECC_OFF_CNT_HI = 8'h04;
    localparam logic [7:0] ECC_OFF_CLEAR = 8'h08;
    localparam logic [7:0] ECC_OFF_RANGE = 8'h0c;
    localparam logic [7:0] ECC_OFF_SETUP = 8'h10;
    localparam logic [7:0] ECC_OFF_LOAD = 8'h14;
    localparam logic [7:0] ECC_OFF_CMPCTL = 8'h18;
    localparam logic [7:0] ECC_OFF_RUN = 8'h1c;
    localparam logic [7:0] ECC_OFF_NTGT = 8'h20;
    localparam logic [7:0] ECC_OFF_STATUS = 8'h24;
    localparam logic [7:0] ECC_OFF_TABLE = 8'h40;
    // setup word fields
    localparam int ECC_SETUP_EN = 0;
    localparam int ECC_SETUP_INCR = 1;
    localparam int ECC_SETUP_SWRST = 2;
    localparam logic [15:0] ECC_SETUP_RESET = 16'h0000;
    // load codes and compare operands
    localparam logic [1:0] ECC_LD_TGT_GO = 2'h0;
    localparam logic [1:0] ECC_LD_RNG_GO = 2'h1;
    localparam logic [1:0] ECC_LD_TGT = 2'h2;
    localparam logic [1:0] ECC_LD_RNG = 2'h3;
    localparam logic [1:0] ECC_CMP_START = 2'h0;
    localparam logic [1:0] ECC_CMP_STOP = 2'h1;
    localparam logic [3:0] ECC_NEG_DIGIT = 4'hf;
    typedef enum {ECC_IDLE, ECC_COPY, ECC_ARMED} ecc_tab_state_t;
endpackage

/* core/ecc_top.sv */
// Purpose: built-in high-speed counter with target and range comparison
// Assumes: pins synchronous to clock; APB slave with no wait states
// Notes: event outputs pulse on each target-match cycle or range entry; one bit per target entry, or per range in range mode
`timescale 1ns/1ps
module ecc_top #(
    parameter int SCAN_CYCLES = ecc_pkg::ECC_SCAN_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // encoder pins
    input wire logic phase_a_input,
    input wire logic phase_b_input,
    input wire logic index_reset_input,
    // freed pins as ordinary inputs
    output logic phase_b_plain,
    output logic index_plain,
    // comparison events
    output logic [15:0] match_event,
    output logic [7:0] range_flags
);
    import ecc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // apb handshake: data registered in setup, answered in access
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic wr_en;
    logic [31:0] rd_d;
    logic map_hit;
    logic [15:0] pv_lo_q, pv_hi_q, clear_ctl_q, setup_q, setup_live_q;
    logic [4:0] ntgt_q;
    logic run_q;
    logic [31:0] stage_q [ECC_NTAB];
    logic signed [ECC_CW-1:0] tab_q [ECC_NTAB];
    logic [7:0] range_q;
    ecc_tab_state_t tab_state_q;
    logic cmp_on_q, range_mode_q, go_after_q;

    // an errored access never writes, so pslverr doubles as the write guard
    assign wr_en = psel & penable & pready_q & pwrite & ~pslverr_q;

    always_comb begin
        rd_d = 32'h0000_0000;
        map_hit = 1'b1;
        if (paddr >= ECC_OFF_TABLE && paddr < ECC_OFF_TABLE + 8'h40 && paddr[1:0] == 2'h0) begin
            rd_d = stage_q[paddr[5:2]];
        end else begin
            case (paddr)
                ECC_OFF_CNT_LO: rd_d = {16'h0000, pv_lo_q};
                ECC_OFF_CNT_HI: rd_d = {16'h0000, pv_hi_q};
                ECC_OFF_CLEAR: rd_d = {16'h0000, clear_ctl_q};
                ECC_OFF_RANGE: rd_d = {24'h000000, range_q};
                ECC_OFF_SETUP: rd_d = {16'h0000, setup_q};
                ECC_OFF_RUN: rd_d = {31'h00000000, run_q};
                ECC_OFF_NTGT: rd_d = {27'h0000000, ntgt_q};
                ECC_OFF_STATUS: rd_d = {28'h0000000, tab_state_q == ECC_COPY, range_mode_q,
                    cmp_on_q, tab_state_q == ECC_ARMED};
                ECC_OFF_LOAD, ECC_OFF_CMPCTL: rd_d = 32'h0000_0000;
                default: map_hit = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else if (psel & ~penable) begin
            prdata_q <= rd_d;
            pready_q <= 1'b1;
            pslverr_q <= ~map_hit;
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software-written state
    logic run_start;
    logic ld_cmd, cc_cmd;
    assign run_start = wr_en && paddr == ECC_OFF_RUN && pwdata[0] && !run_q;
    assign ld_cmd = wr_en && paddr == ECC_OFF_LOAD;
    assign cc_cmd = wr_en && paddr == ECC_OFF_CMPCTL;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            setup_q <= ECC_SETUP_RESET;
            clear_ctl_q <= 16'h0000;
            ntgt_q <= 5'h01;
            run_q <= 1'b0;
        end else if (wr_en) begin
            case (paddr)
                ECC_OFF_SETUP: setup_q <= pwdata[15:0];
                ECC_OFF_CLEAR: clear_ctl_q <= pwdata[15:0];
                ECC_OFF_NTGT: ntgt_q <= (pwdata[4:0] == 5'h00 || pwdata[4:0] > 5'h10) ? 5'h10 : pwdata[4:0];
                ECC_OFF_RUN: run_q <= pwdata[0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (wr_en && paddr >= ECC_OFF_TABLE && paddr < ECC_OFF_TABLE + 8'h40) begin
            stage_q[paddr[5:2]] <= pwdata;
        end
    end

    // the live setup is a snapshot; editing setup while running has no effect
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            setup_live_q <= ECC_SETUP_RESET;
        end else if (run_start) begin
            setup_live_q <= setup_q;
        end
    end

    logic cnt_en, incr_mode, sw_only;
    assign cnt_en = setup_live_q[ECC_SETUP_EN];
    assign incr_mode = setup_live_q[ECC_SETUP_INCR];
    assign sw_only = setup_live_q[ECC_SETUP_SWRST];

    ////////////////////////////////////////////////////////////////////////
    // pin decode
    logic a_q, b_q, z_q;
    logic [1:0] pos_old, pos_new, step;
    function automatic logic [1:0] ecc_pos(input logic a, input logic b);
        // gray order 00, 10, 11, 01 is one forward quarter per step
        case ({a, b})
            2'b00: ecc_pos = 2'h0;
            2'b10: ecc_pos = 2'h1;
            2'b11: ecc_pos = 2'h2;
            default: ecc_pos = 2'h3;
        endcase
    endfunction
    assign pos_old = ecc_pos(a_q, b_q);
    assign pos_new = ecc_pos(phase_a_input, phase_b_input);
    assign step = pos_new - pos_old;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            a_q <= 1'b0;
            b_q <= 1'b0;
            z_q <= 1'b0;
            phase_b_plain <= 1'b0;
            index_plain <= 1'b0;
        end else begin
            a_q <= phase_a_input;
            b_q <= phase_b_input;
            z_q <= index_reset_input;
            phase_b_plain <= (incr_mode || !cnt_en) ? phase_b_input : 1'b0;
            index_plain <= (sw_only || !cnt_en) ? index_reset_input : 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // count
    logic signed [ECC_CW-1:0] count_q;
    logic clr_now;
    logic inc, dec;
    // index method: the clear bit arms, the index rising edge clears
    assign clr_now = clear_ctl_q[0] && (sw_only || (index_reset_input && !z_q));
    assign inc = incr_mode ? (phase_a_input && !a_q) : (step == 2'h1);
    assign dec = !incr_mode && step == 2'h3;

    // saturates at the mode limits; overflow status is not kept, so software sees a stuck value
    always_ff @(posedge clock) begin
        if (!rst_n || run_start || clr_now) begin
            count_q <= '0;
        end else if (cnt_en && inc) begin
            if (incr_mode ? count_q < ECC_CW'(65535) : count_q < ECC_CW'(32767)) begin
                count_q <= count_q + ECC_CW'(1);
            end
        end else if (cnt_en && dec && count_q > -ECC_CW'(32768)) begin
            count_q <= count_q - ECC_CW'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // scan tick and digit words
    localparam int SCW = $clog2(SCAN_CYCLES + 1);
    logic [SCW-1:0] scan_cnt_q;
    logic scan_tick;
    assign scan_tick = scan_cnt_q == SCW'(SCAN_CYCLES - 1);
    always_ff @(posedge clock) begin
        if (!rst_n || scan_tick) begin
            scan_cnt_q <= '0;
        end else begin
            scan_cnt_q <= scan_cnt_q + SCW'(1);
        end
    end

    function automatic logic [19:0] ecc_bcd(input logic [16:0] bin);
        logic [19:0] d;
        d = 20'h00000;
        for (int i = 16; i >= 0; i--) begin
            for (int k = 0; k < 5; k++) begin
                if (d[k*4 +: 4] > 4'h4) begin
                    d[k*4 +: 4] = d[k*4 +: 4] + 4'h3;
                end
            end
            d = {d[18:0], bin[i]};
        end
        return d;
    endfunction

    logic [16:0] mag;
    logic [31:0] pv_word;
    assign mag = count_q[ECC_CW-1] ? 17'(-count_q) : count_q[16:0];
    assign pv_word = {count_q[ECC_CW-1] ? ECC_NEG_DIGIT : 4'h0, 8'h00, ecc_bcd(mag)};

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pv_lo_q <= 16'h0000;
            pv_hi_q <= 16'h0000;
        end else if (cnt_en) begin
            if (run_start || scan_tick) begin
                pv_lo_q <= pv_word[15:0];
                pv_hi_q <= pv_word[31:16];
            end
        end else if (wr_en && paddr == ECC_OFF_CNT_LO) begin
            pv_lo_q <= pwdata[15:0];
        end else if (wr_en && paddr == ECC_OFF_CNT_HI) begin
            pv_hi_q <= pwdata[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // table load and compare control
    logic [3:0] copy_idx_q;
    always_ff @(posedge clock) begin
        if (!rst_n || run_start) begin
            tab_state_q <= ECC_IDLE;
            cmp_on_q <= 1'b0;
            range_mode_q <= 1'b0;
            go_after_q <= 1'b0;
            copy_idx_q <= 4'h0;
        end else if (ld_cmd) begin
            tab_state_q <= ECC_COPY;
            cmp_on_q <= 1'b0;
            range_mode_q <= pwdata[1:0] == ECC_LD_RNG_GO || pwdata[1:0] == ECC_LD_RNG;
            go_after_q <= pwdata[1:0] == ECC_LD_TGT_GO || pwdata[1:0] == ECC_LD_RNG_GO;
            copy_idx_q <= 4'h0;
        end else begin
            case (tab_state_q)
                ECC_COPY: begin
                    copy_idx_q <= copy_idx_q + 4'h1;
                    if (copy_idx_q == 4'hf) begin
                        tab_state_q <= ECC_ARMED;
                        cmp_on_q <= go_after_q;
                    end
                end
                ECC_ARMED: begin
                    if (cc_cmd && pwdata[1:0] == ECC_CMP_STOP) begin
                        cmp_on_q <= 1'b0;
                    end else if (cc_cmd && pwdata[1:0] == ECC_CMP_START) begin
                        cmp_on_q <= 1'b1;
                    end
                end
                ECC_IDLE: cmp_on_q <= 1'b0;
                default: tab_state_q <= ECC_IDLE;
            endcase
        end
    end

    // held until the next load overwrites it
    always_ff @(posedge clock) begin
        if (tab_state_q == ECC_COPY) begin
            tab_q[copy_idx_q] <= stage_q[copy_idx_q][ECC_CW-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // target and range comparison
    logic [3:0] tgt_idx_q;
    logic tgt_hit;
    logic [7:0] in_range;
    assign tgt_hit = cmp_on_q && !range_mode_q && count_q == tab_q[tgt_idx_q];

    genvar g;
    generate
        for (g = 0; g < ECC_NRANGE; g++) begin : g_rng
            // entries 0..7 lower limits, 8..15 upper limits
            assign in_range[g] = count_q >= tab_q[g] && count_q <= tab_q[g + ECC_NRANGE];
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (!rst_n || ld_cmd || run_start) begin
            tgt_idx_q <= 4'h0;
        end else if (tgt_hit) begin
            tgt_idx_q <= (5'(tgt_idx_q) + 5'h01 >= ntgt_q) ? 4'h0 : tgt_idx_q + 4'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            range_q <= 8'h00;
            match_event <= 16'h0000;
        end else begin
            match_event <= 16'h0000;
            if (cmp_on_q && range_mode_q) begin
                range_q <= in_range;
                match_event <= {8'h00, in_range & ~range_q};
            end else begin
                range_q <= 8'h00;
                if (tgt_hit) begin
                    match_event <= 16'h0001 << tgt_idx_q;
                end
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign range_flags = range_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    chk_load_go_starts: assert property (@(posedge clock) disable iff (!rst_n)
        tab_state_q == ECC_COPY && copy_idx_q == 4'hf && go_after_q && !ld_cmd && !run_start
        |=> cmp_on_q) else $error("load-and-start did not begin comparison");
    chk_load_only_idle: assert property (@(posedge clock) disable iff (!rst_n)
        ld_cmd && pwdata[1] |=> !cmp_on_q [*8]) else $error("load-only code started comparison");
    chk_no_cmp_copy: assert property (@(posedge clock) disable iff (!rst_n)
        tab_state_q != ECC_ARMED |-> !cmp_on_q) else $error("comparing without a loaded table");
    chk_stop_halts: assert property (@(posedge clock) disable iff (!rst_n)
        cc_cmd && pwdata[1:0] == ECC_CMP_STOP && tab_state_q == ECC_ARMED && !run_start
        |=> !cmp_on_q ##1 match_event == 16'h0000) else $error("stop did not halt comparison");
    chk_clear_zero: assert property (@(posedge clock) disable iff (!rst_n)
        clr_now |=> count_q == 0) else $error("clear bit did not clear count");
    chk_run_clears: assert property (@(posedge clock) disable iff (!rst_n)
        run_start |=> count_q == 0 && setup_live_q == $past(setup_q)) else $error("run start missed clear");
    chk_setup_frozen: assert property (@(posedge clock) disable iff (!rst_n)
        !run_start |=> setup_live_q == $past(setup_live_q)) else $error("setup changed while running");
    chk_incr_range: assert property (@(posedge clock) disable iff (!rst_n)
        cnt_en && incr_mode |-> count_q >= 0) else $error("incrementing count went negative");
    chk_pv_refresh: assert property (@(posedge clock) disable iff (!rst_n)
        cnt_en && !scan_tick && !run_start |=> $stable(pv_lo_q) && $stable(pv_hi_q))
        else $error("count words changed between scans");
    chk_target_event: assert property (@(posedge clock) disable iff (!rst_n)
        tgt_hit |=> match_event[$past(tgt_idx_q)]) else $error("target match gave no event");
    chk_range_flag: assert property (@(posedge clock) disable iff (!rst_n)
        cmp_on_q && range_mode_q |=> range_q == $past(in_range)) else $error("range flags wrong");
    chk_free_pin: assert property (@(posedge clock) disable iff (!rst_n)
        incr_mode |=> phase_b_plain == $past(phase_b_input)) else $error("phase b pin not freed");
    chk_index_held: assert property (@(posedge clock) disable iff (!rst_n)
        cnt_en && !sw_only |=> !index_plain) else $error("index pin shown while counter uses it");
    chk_storage_word: assert property (@(posedge clock) disable iff (!rst_n)
        !cnt_en && wr_en && paddr == ECC_OFF_CNT_LO |=> pv_lo_q == $past(pwdata[15:0]))
        else $error("disabled count word not writable");
    chk_flags_cleared: assert property (@(posedge clock) disable iff (!rst_n)
        !(cmp_on_q && range_mode_q) |=> range_q == 8'h00) else $error("range flags set while not comparing");

    cov_target_wrap: cover property (@(posedge clock) disable iff (!rst_n)
        tgt_hit && tgt_idx_q != 4'h0 ##1 tgt_idx_q == 4'h0);
    cov_range_hit: cover property (@(posedge clock) disable iff (!rst_n) |match_event && range_mode_q);
    cov_index_clear: cover property (@(posedge clock) disable iff (!rst_n) clr_now && !sw_only);
    cov_load_only: cover property (@(posedge clock) disable iff (!rst_n) ld_cmd && pwdata[1]);
    cov_negative: cover property (@(posedge clock) disable iff (!rst_n) pv_hi_q[15:12] == ECC_NEG_DIGIT);
endmodule
